// *** design/dtep_pkg.sv ***
// Contract
// - eight remote unit configurations per card
// - load reads image back, write sends it
// - connector kind detected, never user settable
// - sync default; async frames 8 to 11 bits
// - async rates below 1.2k up to 38.4k, except 32k
// - sync rates 1.2k through 128k
// - port clock source is always internal
// - carrier detect off, on, or remote rts
// - carrier drop delay 5 to 80 bits
// - carrier drop delay rounds up to step
// - data set ready forced off or on
// - clear to send off, on, or local rts
// - cts delay in bits or milliseconds
// - cts delay rounds up to next value
// - async rate tuning offset or exact
// - ring output switchable, default off
// - remote loop requests always ignored
// - local loop permitted; panel switch forces it
// - console reads allowed, writes never, disable hides
// - network test loops line path, default off
// - network test loop released after fifteen minutes; local loop is not timed
// - loop status none, local, net, both
package dtep_pkg;
  localparam int CLK_HZ = 50_000_000;
  localparam int MS_PER_S = 1000;
  localparam int MS_CYCLES = CLK_HZ / MS_PER_S;
  localparam int LOOP_TIMEOUT_MIN = 15;
  localparam int LOOP_TIMEOUT_MS = LOOP_TIMEOUT_MIN * 60 * MS_PER_S;
  localparam int UNIT_COUNT = 8;
  localparam int UNIT_W = 3;
  localparam int LT_W = 20;
  localparam int MS_W = 16;
  localparam int DIV_W = 17;
  localparam int OFFSET_SHIFT = 6;
  localparam int SYNC_W = 6;
  // register byte offsets
  localparam int ADDR_W = 8;
  localparam logic [7:0] ADDR_UNIT_SEL = 8'h00;
  localparam logic [7:0] ADDR_CONFIG = 8'h04;
  localparam logic [7:0] ADDR_ACTION = 8'h08;
  localparam logic [7:0] ADDR_STATUS = 8'h0C;
  localparam logic [7:0] ADDR_IMAGE = 8'h10;
  localparam logic [7:0] ADDR_TEST = 8'h14;
  localparam int ACT_LOAD_BIT = 0;
  localparam int ACT_WRITE_BIT = 1;
  localparam int ST_KIND_BIT = 0;
  localparam int ST_LOOP_LO = 1;
  localparam int ST_CLK_INT_BIT = 3;
  localparam int ST_TIMER_BIT = 4;
  localparam int ST_CTS_BIT = 5;
  localparam int ST_DCD_BIT = 6;
  localparam int ST_DSR_BIT = 7;
  localparam int ST_RI_BIT = 8;
  localparam logic CLOCK_INTERNAL = 1'b1;
  localparam logic TIMER_ON = 1'b1;
  // framing and signal option codes
  localparam logic [2:0] FRAME_SYNC = 3'h0;
  localparam logic [2:0] FRAME_ASYNC_EIGHT_BIT_FRAME = 3'h1;
  localparam logic [2:0] FRAME_ASYNC_ELEVEN_BIT_FRAME = 3'h4;
  localparam logic [1:0] SIG_OFF = 2'h0;
  localparam logic [1:0] SIG_ON = 2'h1;
  localparam logic [1:0] SIG_FOLLOW = 2'h2;
  // rate codes
  localparam logic [3:0] RATE_SUB_1K2 = 4'h0;
  localparam logic [3:0] RATE_1K2 = 4'h1;
  localparam logic [3:0] RATE_32K = 4'h8;
  localparam logic [3:0] RATE_38K4 = 4'h9;
  localparam logic [3:0] RATE_64K = 4'hC;
  localparam logic [3:0] RATE_128K = 4'hE;
  localparam int RATE_COUNT = 15;
  localparam int RATE_DIV [RATE_COUNT] = '{CLK_HZ / 600, CLK_HZ / 1200, CLK_HZ / 2400,
    CLK_HZ / 4800, CLK_HZ / 9600, CLK_HZ / 14400, CLK_HZ / 19200, CLK_HZ / 28800,
    CLK_HZ / 32000, CLK_HZ / 38400, CLK_HZ / 48000, CLK_HZ / 56000, CLK_HZ / 64000,
    CLK_HZ / 72000, CLK_HZ / 128000};
  // delay steps
  localparam int DCD_STEP = 5;
  localparam int DCD_STEPS = 16;
  localparam int CTS_BIT_STEP = 10;
  localparam int CTS_BIT_STEPS = 6;
  localparam int CTS_MS_STEPS = 7;
  localparam logic [7:0] CTS_MS_STEP [CTS_MS_STEPS] = '{8'h0A, 8'h14, 8'h1E, 8'h28, 8'h32,
    8'h64, 8'hFA};

  typedef struct packed {
    logic [2:0] framing_select;
    logic [3:0] rate;
    logic [1:0] dcd_mode;
    logic [6:0] carrier_drop_delay;
    logic dsr_on;
    logic [1:0] cts_mode;
    logic cts_in_ms;
    logic [7:0] cts_delay;
    logic async_rate_exact;
    logic ring_output_enable;
    logic local_loop_permit;
    logic console_enable;
  } dtep_cfg_t;

  localparam dtep_cfg_t CFG_RESET = '{framing_select: FRAME_SYNC, rate: RATE_64K,
    dcd_mode: SIG_ON, carrier_drop_delay: 7'h00, dsr_on: 1'b1, cts_mode: SIG_ON,
    cts_in_ms: 1'b0, cts_delay: 8'h00, async_rate_exact: 1'b0, ring_output_enable: 1'b0,
    local_loop_permit: 1'b1, console_enable: 1'b1};

  typedef struct packed {
    logic net;
    logic loc;
  } dtep_loop_t;

  typedef struct packed {
    logic valid;
    logic write;
    logic hit;
    logic [7:0] addr;
  } dtep_ahb_ap_t;
endpackage

// *** design/dtep_tick_delay.sv ***
`timescale 1ns/1ps
module dtep_tick_delay #(
  parameter int W = 8
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic start,
  input wire logic stop,
  input wire logic tick,
  input wire logic [W-1:0] load_val,
  output logic busy,
  output logic done
);
  logic [W-1:0] cnt_q;
  logic [W-1:0] cnt_d;
  logic run_q;
  logic run_d;

  // stop beats start; count down on ticks
  always_comb
  begin
    cnt_d = cnt_q;
    run_d = run_q;
    if (stop)
      run_d = 1'b0;
    else if (start)
    begin
      run_d = 1'b1;
      cnt_d = load_val;
    end
    else if (run_q && tick && cnt_q != '0)
      cnt_d = cnt_q - 1'b1;
  end

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      cnt_q <= '0;
      run_q <= 1'b0;
    end
    else
    begin
      cnt_q <= cnt_d;
      run_q <= run_d;
    end
  end

  assign busy = run_q && cnt_q != '0;
  assign done = run_q && cnt_q == '0;
endmodule

// *** design/dtep_port_ctrl.sv ***
// Our own choices: register access over AHB-Lite and the register addresses.
`timescale 1ns/1ps
module dtep_port_ctrl
  import dtep_pkg::*;
#(
  parameter int MS_CYCLES_P = MS_CYCLES,
  parameter int LOOP_TIMEOUT_MS_P = LOOP_TIMEOUT_MS
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic rts_local_pin,
  input wire logic rts_remote_pin,
  input wire logic ring_pin,
  input wire logic term_loop_req_pin,
  input wire logic panel_loop_sw_pin,
  input wire logic terminal_connector_kind_pin,
  output logic carrier_detect,
  output logic data_set_ready,
  output logic clear_to_send,
  output logic ring_indicate,
  output logic local_loop_on,
  output logic net_loop_on,
  output logic bit_strobe,
  output logic console_view_en,
  output logic console_write_en,
  output logic [31:0] console_data
);
  dtep_ahb_ap_t ap_q;
  dtep_ahb_ap_t ap_d;
  logic [31:0] rd_q;
  logic [31:0] rd_d;
  logic [UNIT_W-1:0] sel_q;
  logic [UNIT_W-1:0] sel_d;
  dtep_cfg_t saved_q [UNIT_COUNT];
  dtep_cfg_t saved_d [UNIT_COUNT];
  dtep_cfg_t image_q [UNIT_COUNT];
  dtep_cfg_t image_d [UNIT_COUNT];
  logic net_test_q;
  logic net_test_d;
  logic [SYNC_W-1:0] sync1_q;
  logic [SYNC_W-1:0] sync2_q;
  logic [DIV_W-1:0] div_q;
  logic [DIV_W-1:0] div_d;
  logic [MS_W-1:0] ms_q;
  logic [MS_W-1:0] ms_d;
  logic [LT_W-1:0] lt_q;
  logic [LT_W-1:0] lt_d;
  logic bit_tick_q;
  logic bit_tick_d;
  logic ms_tick_q;
  logic ms_tick_d;
  logic rts_l_prev_q;
  logic rts_r_prev_q;
  logic dcd_q;
  logic dcd_d;
  logic dsr_q;
  logic dsr_d;
  logic cts_q;
  logic cts_d;
  logic ri_q;
  logic ri_d;
  dtep_loop_t loop_q;
  dtep_loop_t loop_d;
  logic view_q;
  logic [31:0] cdata_q;
  logic [31:0] cdata_d;
  dtep_cfg_t act;
  logic wr_en;
  logic rts_l;
  logic rts_r;
  logic ring_s;
  logic loop_req_s;
  logic panel_s;
  logic kind_s;
  logic timeout_hit;
  logic test_wr;
  logic [DIV_W-1:0] divisor;
  logic cts_done;
  logic dcd_busy;
  logic [31:0] status;

  // legalise a written config word against the allowed option values
  function automatic dtep_cfg_t dtep_round_cfg(input dtep_cfg_t n, input dtep_cfg_t o);
    dtep_cfg_t r;
    logic ok;
    r = n;
    if (n.framing_select > FRAME_ASYNC_ELEVEN_BIT_FRAME)
      r.framing_select = o.framing_select;
    if (r.framing_select == FRAME_SYNC)
      ok = n.rate != RATE_SUB_1K2 && n.rate <= RATE_128K;
    else
      ok = n.rate <= RATE_38K4 && n.rate != RATE_32K;
    if (!ok)
      r.rate = RATE_1K2;
    if (n.dcd_mode > SIG_FOLLOW)
      r.dcd_mode = o.dcd_mode;
    if (n.cts_mode > SIG_FOLLOW)
      r.cts_mode = o.cts_mode;
    // delay only exists in follow mode
    if (r.dcd_mode != SIG_FOLLOW)
      r.carrier_drop_delay = 7'h00;
    else
    begin
      r.carrier_drop_delay = 7'(DCD_STEPS * DCD_STEP);
      for (int i = DCD_STEPS; i >= 1; i--)
        if (n.carrier_drop_delay <= 7'(i * DCD_STEP))
          r.carrier_drop_delay = 7'(i * DCD_STEP);
    end
    if (r.cts_mode != SIG_FOLLOW)
    begin
      r.cts_delay = 8'h00;
      r.cts_in_ms = 1'b0;
    end
    else if (n.cts_in_ms)
    begin
      r.cts_delay = CTS_MS_STEP[CTS_MS_STEPS-1];
      for (int i = CTS_MS_STEPS - 1; i >= 0; i--)
        if (n.cts_delay <= CTS_MS_STEP[i])
          r.cts_delay = CTS_MS_STEP[i];
    end
    else
    begin
      r.cts_delay = 8'(CTS_BIT_STEPS * CTS_BIT_STEP);
      for (int i = CTS_BIT_STEPS; i >= 0; i--)
        if (n.cts_delay <= 8'(i * CTS_BIT_STEP))
          r.cts_delay = 8'(i * CTS_BIT_STEP);
    end
    return r;
  endfunction

  // pin synchronisers
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      sync1_q <= '0;
      sync2_q <= '0;
    end
    else
    begin
      sync1_q <= {terminal_connector_kind_pin, panel_loop_sw_pin, term_loop_req_pin,
        ring_pin, rts_remote_pin, rts_local_pin};
      sync2_q <= sync1_q;
    end
  end

  assign rts_l = sync2_q[0];
  assign rts_r = sync2_q[1];
  assign ring_s = sync2_q[2];
  assign loop_req_s = sync2_q[3];
  assign panel_s = sync2_q[4];
  assign kind_s = sync2_q[5];
  // the port runs from the downloaded image of the selected unit
  assign act = image_q[sel_q];
  assign wr_en = ap_q.valid && ap_q.write && ap_q.hit;
  assign test_wr = wr_en && ap_q.addr == ADDR_TEST;

  // register file next state
  always_comb
  begin
    sel_d = sel_q;
    saved_d = saved_q;
    image_d = image_q;
    net_test_d = net_test_q;
    if (wr_en)
    begin
      case (ap_q.addr)
        ADDR_UNIT_SEL: sel_d = hwdata[UNIT_W-1:0];
        ADDR_CONFIG: saved_d[sel_q] = dtep_round_cfg(hwdata, saved_q[sel_q]);
        ADDR_ACTION:
        begin
          if (hwdata[ACT_LOAD_BIT])
            saved_d[sel_q] = image_q[sel_q];
          if (hwdata[ACT_WRITE_BIT])
            image_d[sel_q] = saved_q[sel_q];
        end
        ADDR_TEST: net_test_d = hwdata[0];
        default: ;
      endcase
    end
    // timer ends the loop unless software writes the test bit now
    if (timeout_hit && !test_wr)
      net_test_d = 1'b0;
  end

  // status word; no remote loop state exists since such requests are dropped
  always_comb
  begin
    status = '0;
    status[ST_KIND_BIT] = kind_s;
    status[ST_LOOP_LO+1:ST_LOOP_LO] = loop_q;
    status[ST_CLK_INT_BIT] = CLOCK_INTERNAL;
    status[ST_TIMER_BIT] = TIMER_ON;
    status[ST_CTS_BIT] = cts_q;
    status[ST_DCD_BIT] = dcd_q;
    status[ST_DSR_BIT] = dsr_q;
    status[ST_RI_BIT] = ri_q;
  end

  // address phase capture and read data from next-state values
  always_comb
  begin
    ap_d.valid = hsel && hready && htrans[1];
    ap_d.write = hwrite;
    ap_d.hit = haddr[31:ADDR_W] == '0 && hsize == 3'h2;
    ap_d.addr = haddr[ADDR_W-1:0];
    rd_d = '0;
    if (ap_d.valid && !ap_d.write && ap_d.hit)
    begin
      case (ap_d.addr)
        ADDR_UNIT_SEL: rd_d = 32'(sel_d);
        ADDR_CONFIG: rd_d = saved_d[sel_d];
        ADDR_STATUS: rd_d = status;
        ADDR_IMAGE: rd_d = image_d[sel_d];
        ADDR_TEST: rd_d = 32'(net_test_d);
        default: rd_d = '0;
      endcase
    end
  end

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      ap_q <= '0;
      rd_q <= '0;
      sel_q <= '0;
      net_test_q <= 1'b0;
      for (int i = 0; i < UNIT_COUNT; i++)
      begin
        saved_q[i] <= CFG_RESET;
        image_q[i] <= CFG_RESET;
      end
    end
    else
    begin
      ap_q <= ap_d;
      rd_q <= rd_d;
      sel_q <= sel_d;
      net_test_q <= net_test_d;
      saved_q <= saved_d;
      image_q <= image_d;
    end
  end

  // bit period from the internal reference; async offset runs slightly slow
  always_comb
  begin
    divisor = DIV_W'(RATE_DIV[act.rate]);
    if (act.framing_select != FRAME_SYNC && !act.async_rate_exact)
      divisor = divisor + (divisor >> OFFSET_SHIFT);
    bit_tick_d = div_q == '0;
    div_d = bit_tick_d ? divisor - 1'b1 : div_q - 1'b1;
    ms_tick_d = ms_q == '0;
    ms_d = ms_tick_d ? MS_W'(MS_CYCLES_P - 1) : ms_q - 1'b1;
    timeout_hit = net_test_q && ms_tick_q && lt_q == LT_W'(LOOP_TIMEOUT_MS_P - 1);
    if (!net_test_q || timeout_hit)
      lt_d = '0;
    else if (ms_tick_q)
      lt_d = lt_q + 1'b1;
    else
      lt_d = lt_q;
  end

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      div_q <= '0;
      ms_q <= '0;
      lt_q <= '0;
      bit_tick_q <= 1'b0;
      ms_tick_q <= 1'b0;
    end
    else
    begin
      div_q <= div_d;
      ms_q <= ms_d;
      lt_q <= lt_d;
      bit_tick_q <= bit_tick_d;
      ms_tick_q <= ms_tick_d;
    end
  end

  // cts turn-on delay after local rts rises
  dtep_tick_delay #(
    .W(8)
  ) u_cts_delay (
    .ref_clk(ref_clk),
    .rst(rst),
    .start(rts_l && !rts_l_prev_q),
    .stop(!rts_l),
    .tick(act.cts_in_ms ? ms_tick_q : bit_tick_q),
    .load_val(act.cts_delay),
    .busy(),
    .done(cts_done)
  );

  // carrier hold after remote rts falls
  dtep_tick_delay #(
    .W(7)
  ) u_dcd_delay (
    .ref_clk(ref_clk),
    .rst(rst),
    .start(!rts_r && rts_r_prev_q),
    .stop(rts_r),
    .tick(bit_tick_q),
    .load_val(act.carrier_drop_delay),
    .busy(dcd_busy),
    .done()
  );

  // terminal-side outputs
  always_comb
  begin
    unique case (act.dcd_mode)
      SIG_OFF: dcd_d = 1'b0;
      SIG_FOLLOW: dcd_d = rts_r || rts_r_prev_q || dcd_busy;
      default: dcd_d = 1'b1;
    endcase
    unique case (act.cts_mode)
      SIG_OFF: cts_d = 1'b0;
      SIG_FOLLOW: cts_d = rts_l && rts_l_prev_q && cts_done;
      default: cts_d = 1'b1;
    endcase
    dsr_d = act.dsr_on;
    ri_d = ring_s && act.ring_output_enable;
    loop_d.loc = (loop_req_s && act.local_loop_permit) || panel_s;
    loop_d.net = net_test_q;
    cdata_d = act.console_enable ? act : '0;
  end

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      rts_l_prev_q <= 1'b0;
      rts_r_prev_q <= 1'b0;
      dcd_q <= 1'b0;
      cts_q <= 1'b0;
      dsr_q <= 1'b0;
      ri_q <= 1'b0;
      loop_q <= '0;
      view_q <= 1'b0;
      cdata_q <= '0;
    end
    else
    begin
      rts_l_prev_q <= rts_l;
      rts_r_prev_q <= rts_r;
      dcd_q <= dcd_d;
      cts_q <= cts_d;
      dsr_q <= dsr_d;
      ri_q <= ri_d;
      loop_q <= loop_d;
      view_q <= act.console_enable;
      cdata_q <= cdata_d;
    end
  end

  // outputs
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = rd_q;
  assign carrier_detect = dcd_q;
  assign data_set_ready = dsr_q;
  assign clear_to_send = cts_q;
  assign ring_indicate = ri_q;
  assign local_loop_on = loop_q.loc;
  assign net_loop_on = loop_q.net;
  assign bit_strobe = bit_tick_q;
  assign console_view_en = view_q;
  assign console_write_en = 1'b0;
  assign console_data = cdata_q;
endmodule

// *** bench/dtep_port_ctrl_properties.sv ***
`timescale 1ns/1ps
module dtep_port_ctrl_chk
  import dtep_pkg::*;
#(
  parameter int MS_CYCLES_P = MS_CYCLES,
  parameter int LOOP_TIMEOUT_MS_P = LOOP_TIMEOUT_MS
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic [31:0] hrdata,
  input wire logic ring_pin,
  input wire logic term_loop_req_pin,
  input wire logic panel_loop_sw_pin,
  input wire logic ring_indicate,
  input wire logic local_loop_on,
  input wire logic net_loop_on,
  input wire logic bit_strobe,
  input wire logic console_view_en,
  input wire logic console_write_en,
  input wire logic [31:0] console_data
);
  logic rd_q, rd_d, wt_q, wt_d;
  logic [31:0] on_q, on_d;
  // data phase flags and network loop age
  always_comb
  begin
    rd_d = hsel && hready && htrans[1] && !hwrite;
    wt_d = hsel && hready && htrans[1] && hwrite && haddr == {24'h0, ADDR_TEST};
    on_d = net_loop_on ? on_q + 32'h1 : 32'h0;
  end
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      {rd_q, wt_q, on_q} <= '0;
    else
      {rd_q, wt_q, on_q} <= {rd_d, wt_d, on_d};
  end
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (rst);
  property p_okay; hreadyout && !hresp; endproperty
  a_okay: assert property (p_okay) else $error("bus not ready or not okay");
  property p_rd_idle; !rd_q |-> hrdata == 32'h0; endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data outside data phase");
  property p_strobe; bit_strobe |=> !bit_strobe [*8]; endproperty
  a_strobe: assert property (p_strobe) else $error("bit strobe too close");
  property p_panel; panel_loop_sw_pin [*4] |-> local_loop_on; endproperty
  a_panel: assert property (p_panel) else $error("panel switch ignored");
  property p_loc_off; (!panel_loop_sw_pin && !term_loop_req_pin) [*4] |-> !local_loop_on;
  endproperty
  a_loc_off: assert property (p_loc_off) else $error("local loop without request");
  property p_ring; !ring_pin [*4] |-> !ring_indicate; endproperty
  a_ring: assert property (p_ring) else $error("ring without ring pin");
  property p_net_cause; $rose(net_loop_on) |-> wt_q || $past(wt_q) || $past(wt_q, 2);
  endproperty
  a_net_cause: assert property (p_net_cause) else $error("net loop without test write");
  property p_net_time; on_q <= longint'(MS_CYCLES_P) * (LOOP_TIMEOUT_MS_P + 2); endproperty
  a_net_time: assert property (p_net_time) else $error("net loop not released");
  property p_no_wr; !console_write_en; endproperty
  a_no_wr: assert property (p_no_wr) else $error("console write enabled");
  property p_hide; !console_view_en |-> console_data == 32'h0; endproperty
  a_hide: assert property (p_hide) else $error("console data shown while hidden");
  c_net: cover property ($fell(net_loop_on));
  c_panel: cover property (panel_loop_sw_pin && local_loop_on);
  c_hide: cover property (!console_view_en);
endmodule
bind dtep_port_ctrl dtep_port_ctrl_chk #(
  .MS_CYCLES_P(MS_CYCLES_P),
  .LOOP_TIMEOUT_MS_P(LOOP_TIMEOUT_MS_P)
) chk_u (.*);

// *** bench/dtep_term_model.sv ***
`timescale 1ns/1ps
module dtep_term_model (
  input wire logic ref_clk,
  input wire logic [5:0] cmd,
  output logic [5:0] pins
);
  // terminal levels change just after an edge
  always_ff @(posedge ref_clk)
    pins <= cmd;
endmodule

// *** bench/tb.sv ***
`timescale 1ns/1ps
module tb;
  import dtep_pkg::*;
  localparam int MSC = 10;
  localparam int LTM = 4;
  localparam int BIT = CLK_HZ / 128000;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [5:0] pcmd = 6'h00;
  logic [5:0] pins;
  logic [31:0] hrdata, cdata, rv;
  logic hrdy, hresp, cd, dsr, cts, ri, ll, nl, cv, cw, bs;
  int n_mismatch = 0;
  int tests_run = 0;
  int cyc = 0;
  int n = 0;
  dtep_term_model tm_u (.ref_clk(ref_clk), .cmd(pcmd), .pins(pins));
  dtep_port_ctrl #(.MS_CYCLES_P(MSC), .LOOP_TIMEOUT_MS_P(LTM)) dut_u (
    .ref_clk(ref_clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hrdy), .hreadyout(hrdy),
    .hresp(hresp), .hrdata(hrdata), .rts_local_pin(pins[0]), .rts_remote_pin(pins[1]),
    .ring_pin(pins[2]), .term_loop_req_pin(pins[3]), .panel_loop_sw_pin(pins[4]),
    .terminal_connector_kind_pin(pins[5]), .carrier_detect(cd), .data_set_ready(dsr),
    .clear_to_send(cts), .ring_indicate(ri), .local_loop_on(ll), .net_loop_on(nl),
    .bit_strobe(bs), .console_view_en(cv), .console_write_en(cw), .console_data(cdata));
  // config word builders
  function automatic logic [31:0] mk(input logic [2:0] f, input logic [3:0] r,
    input logic [1:0] dm, input logic [6:0] dd, input logic ds, input logic [1:0] cm,
    input logic ms, input logic [7:0] cl, input logic [3:0] lo);
    return {f, r, dm, dd, ds, cm, ms, cl, lo};
  endfunction
  function automatic logic [31:0] cf(input logic fo, input logic [6:0] dd,
    input logic ms, input logic [7:0] cl);
    return mk(FRAME_SYNC, RATE_128K, fo ? SIG_FOLLOW : SIG_ON, dd, 1'h1,
      fo ? SIG_FOLLOW : SIG_ON, ms, cl, 4'h3);
  endfunction
  function automatic logic [31:0] fr(input logic [2:0] f, input logic [3:0] r,
    input logic [3:0] lo);
    return mk(f, r, SIG_ON, 7'h00, 1'h1, SIG_ON, 1'h0, 8'h00, lo);
  endfunction
  function automatic logic pick(input int k);
    return k == 0 ? cts : (k == 1 ? cd : (k == 2 ? nl : bs));
  endfunction
  localparam logic [31:0] DEF = fr(FRAME_SYNC, RATE_64K, 4'h3);
  // clock and hang guard
  initial
  begin
    forever #10 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 40000)
    begin
      n_mismatch++;
      give_verdict();
    end
  end
  task automatic give_verdict;
    if (n_mismatch == 0 && tests_run > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] s, e);
    tests_run++;
    if (s !== e)
    begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", nm, e, s);
    end
  endtask
  // one single-word transfer, waits on ready each phase
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    hsel <= 1'h1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= w;
    do @(posedge ref_clk); while (hrdy !== 1'h1);
    hsel <= 1'h0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge ref_clk); while (hrdy !== 1'h1);
    rv = hrdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'h1, a, d);
  endtask
  task automatic rd(input string nm, input logic [7:0] a, input logic [31:0] e);
    bus(1'h0, a, 32'h0);
    chk(nm, rv, e);
  endtask
  task automatic rt(input logic [31:0] w, e);
    wr(ADDR_CONFIG, w);
    rd("config", ADDR_CONFIG, e);
  endtask
  task automatic rs(input logic [31:0] w);
    rt(w, w);
  endtask
  task automatic w6;
    repeat (6) @(posedge ref_clk);
  endtask
  task automatic push(input logic [31:0] w);
    wr(ADDR_CONFIG, w);
    wr(ADDR_ACTION, 32'h2);
    w6();
  endtask
  task automatic pin(input int k, input logic v);
    @(posedge ref_clk);
    pcmd[k] <= v;
  endtask
  task automatic cnt(input int k, input logic v);
    n = 0;
    while (pick(k) !== v && n < 9000)
    begin
      @(posedge ref_clk);
      n++;
    end
  endtask
  task automatic inr(input string nm, input int lo, hi);
    chk(nm, {31'h0, n >= lo && n <= hi}, 32'h1);
  endtask
  // cycles from one bit strobe to the next
  task automatic per(input string nm, input int e);
    cnt(3, 1'h1);
    @(posedge ref_clk);
    cnt(3, 1'h1);
    inr(nm, e - 2, e);
  endtask
  task automatic t_reset;
    rd("config", ADDR_CONFIG, DEF);
    rd("status", ADDR_STATUS, 32'h0F8);
    chk("levels", {26'h0, cd, dsr, cts, ri, cv, cw}, 32'h3A);
  endtask
  task automatic t_frame;
    rs(fr(FRAME_ASYNC_EIGHT_BIT_FRAME, RATE_SUB_1K2, 4'h3));
    rs(fr(3'h2, RATE_38K4, 4'hB));
    rs(fr(3'h3, RATE_1K2, 4'h3));
    rt(fr(FRAME_ASYNC_ELEVEN_BIT_FRAME, RATE_64K, 4'h3), fr(FRAME_ASYNC_ELEVEN_BIT_FRAME, RATE_1K2, 4'h3));
    rt(fr(3'h5, RATE_1K2, 4'h3), fr(FRAME_ASYNC_ELEVEN_BIT_FRAME, RATE_1K2, 4'h3));
    rt(fr(FRAME_SYNC, RATE_SUB_1K2, 4'h3), fr(FRAME_SYNC, RATE_1K2, 4'h3));
    rs(fr(FRAME_SYNC, RATE_32K, 4'h3));
  endtask
  task automatic t_round;
    rt(cf(1'h1, 7'h34, 1'h0, 8'h34), cf(1'h1, 7'h37, 1'h0, 8'h3C));
    rt(cf(1'h1, 7'h00, 1'h1, 8'h34), cf(1'h1, 7'h05, 1'h1, 8'h64));
    rt(cf(1'h1, 7'h5A, 1'h1, 8'hFF), cf(1'h1, 7'h50, 1'h1, 8'hFA));
    rt(cf(1'h1, 7'h50, 1'h0, 8'h46), cf(1'h1, 7'h50, 1'h0, 8'h3C));
    rt(cf(1'h1, 7'h05, 1'h1, 8'h03), cf(1'h1, 7'h05, 1'h1, 8'h0A));
    rs(cf(1'h1, 7'h05, 1'h0, 8'h00));
    rt(cf(1'h0, 7'h28, 1'h0, 8'h1E), cf(1'h0, 7'h00, 1'h0, 8'h00));
  endtask
  task automatic t_image;
    wr(ADDR_UNIT_SEL, 32'h7);
    rd("unit", ADDR_UNIT_SEL, 32'h7);
    push(cf(1'h1, 7'h0A, 1'h0, 8'h14));
    rd("image", ADDR_IMAGE, cf(1'h1, 7'h0A, 1'h0, 8'h14));
    wr(ADDR_UNIT_SEL, 32'h0);
    rd("image", ADDR_IMAGE, DEF);
    wr(ADDR_ACTION, 32'h1);
    rd("config", ADDR_CONFIG, DEF);
  endtask
  task automatic t_signals;
    pin(2, 1'h1);
    w6();
    chk("ring", {31'h0, ri}, 32'h0);
    push(mk(FRAME_SYNC, RATE_128K, SIG_OFF, 7'h00, 1'h0, SIG_OFF, 1'h0, 8'h00, 4'h7));
    chk("levels", {28'h0, cd, dsr, cts, ri}, 32'h1);
    push(fr(FRAME_ASYNC_EIGHT_BIT_FRAME, RATE_38K4, 4'h3));
    per("offset", CLK_HZ / 38400 + CLK_HZ / 38400 / 64);
    push(fr(FRAME_ASYNC_EIGHT_BIT_FRAME, RATE_38K4, 4'hB));
    per("exact", CLK_HZ / 38400);
    pin(2, 1'h0);
  endtask
  // follow modes: delays counted in bits and in ms
  task automatic t_follow;
    push(cf(1'h1, 7'h05, 1'h0, 8'h0A));
    per("bit period", BIT);
    pin(0, 1'h1);
    cnt(0, 1'h1);
    inr("cts bits", 9 * BIT, 11 * BIT + 8);
    pin(0, 1'h0);
    cnt(0, 1'h0);
    inr("cts off", 0, 8);
    push(cf(1'h1, 7'h05, 1'h1, 8'h0A));
    pin(0, 1'h1);
    cnt(0, 1'h1);
    inr("cts ms", 9 * MSC, 11 * MSC + 8);
    pin(0, 1'h0);
    pin(1, 1'h1);
    cnt(1, 1'h1);
    inr("dcd on", 0, 8);
    pin(1, 1'h0);
    cnt(1, 1'h0);
    inr("dcd off", 4 * BIT, 6 * BIT + 8);
  endtask
  task automatic t_loops;
    pin(3, 1'h1);
    w6();
    chk("loops", {30'h0, nl, ll}, 32'h1);
    wr(ADDR_TEST, 32'h1);
    bus(1'h0, ADDR_STATUS, 32'h0);
    chk("status", {30'h0, rv[2:1]}, 32'h3);
    cnt(2, 1'h0);
    inr("timeout", (LTM - 1) * MSC - 8, (LTM + 1) * MSC + 8);
    rd("test", ADDR_TEST, 32'h0);
    pin(3, 1'h0);
    push(fr(FRAME_SYNC, RATE_64K, 4'h1));
    rd("status", ADDR_STATUS, 32'h0F8);
    pin(3, 1'h1);
    w6();
    chk("no local", {31'h0, ll}, 32'h0);
    pin(4, 1'h1);
    w6();
    bus(1'h0, ADDR_STATUS, 32'h0);
    chk("status", {30'h0, rv[2:1]}, 32'h1);
    pin(4, 1'h0);
    pin(3, 1'h0);
  endtask
  task automatic t_console;
    push(fr(FRAME_SYNC, RATE_64K, 4'h2));
    chk("view", {31'h0, cv}, 32'h0);
    chk("console", cdata, 32'h0);
    push(DEF);
    chk("console", cdata, DEF);
    pin(5, 1'h1);
    w6();
    wr(ADDR_STATUS, 32'h0);
    bus(1'h0, ADDR_STATUS, 32'h0);
    chk("kind", {31'h0, rv[0]}, 32'h1);
    rd("unmapped", 8'h18, 32'h0);
  endtask
  // main sequence
  initial
  begin
    repeat (12) @(posedge ref_clk);
    rst <= 1'h0;
    t_reset();
    t_frame();
    t_round();
    t_image();
    t_signals();
    t_follow();
    t_loops();
    t_console();
    give_verdict();
  end
endmodule
